// ===== core/dpt_pkg.sv
// Purpose: constants for the dual programmable timer block
// Assumes: 32-bit avalon-mm bus, each register one aligned word at four times its index
// Notes: offsets are register indices; byte address is index * 4
// How it works
// - underflow sets its flag and requests interrupt
// - cleared enable blocks request, flag still sets
// - one shared two-bit priority for both timers
// - timer 1 vector 000006, timer 0 vector 000008
// - chained mode: only timer 1 flag, on 16-bit underflow
// - clock output toggles on each selected underflow
// - source select 0 picks timer 0, 1 timer 1
// - chained mode: 16-bit underflow drives clock output
// - enable drives clock to pin, else pin high
// - output gating may glitch half an output cycle
// - timer 1 underflow clocks the serial interface
// - source select 1 fast, 0 slow, reset 0
// - divider code divides by 1, 4, 16, 64
// - run bit 1 counts, 0 holds, reset 0
// - reload registers read/write, reset to all ones
// - count readouts read-only, reset to all ones
// - enables in bits 7 and 6, reset 0
// - flags in bits 7 and 6, reset 0
// - continuous reloads and runs; one-shot reloads and stops
// - chained: timer 0 low byte, timer 0 controls
// - preset copies reload to counter, reads zero
package dpt_pkg;
    localparam int DPT_ADDR_W = 18;
    localparam logic [15:0] DPT_IDX_PRIO = 16'hff21;
    localparam logic [15:0] DPT_IDX_IEN = 16'hff23;
    localparam logic [15:0] DPT_IDX_FLAG = 16'hff25;
    localparam logic [15:0] DPT_IDX_MODE = 16'hff30;
    localparam logic [15:0] DPT_IDX_CTRL0 = 16'hff31;
    localparam logic [15:0] DPT_IDX_CTRL1 = 16'hff32;
    localparam logic [15:0] DPT_IDX_RLD0 = 16'hff33;
    localparam logic [15:0] DPT_IDX_RLD1 = 16'hff34;
    localparam logic [15:0] DPT_IDX_CNT0 = 16'hff35;
    localparam logic [15:0] DPT_IDX_CNT1 = 16'hff36;
    // mode register fields
    localparam int DPT_B_CHAIN = 4;
    localparam int DPT_B_CLKOUT_SOURCE_SELECT = 3;
    localparam int DPT_B_CKEN = 2;
    localparam int DPT_B_SRC1 = 1;
    localparam int DPT_B_SRC0 = 0;
    // timer control fields
    localparam int DPT_B_DIVHI = 4;
    localparam int DPT_B_DIVLO = 3;
    localparam int DPT_B_CONT = 2;
    localparam int DPT_B_PSET = 1;
    localparam int DPT_B_RUN = 0;
    // priority, enable and flag fields
    localparam int DPT_B_PRIOHI = 3;
    localparam int DPT_B_PRIOLO = 2;
    localparam int DPT_B_T1 = 7;
    localparam int DPT_B_T0 = 6;
    // reset values
    localparam logic [7:0] DPT_RLD_RST = 8'hff;
    localparam logic [7:0] DPT_CNT_RST = 8'hff;
    localparam logic [1:0] DPT_DIV_RST = 2'h0;
    // interrupt vectors
    localparam logic [23:0] DPT_VEC_T1 = 24'h000006;
    localparam logic [23:0] DPT_VEC_T0 = 24'h000008;
    // prescaler terminal masks for /1, /4, /16, /64
    localparam logic [5:0] DPT_MASK_D1 = 6'h00;
    localparam logic [5:0] DPT_MASK_D4 = 6'h03;
    localparam logic [5:0] DPT_MASK_D16 = 6'h0f;
    localparam logic [5:0] DPT_MASK_D64 = 6'h3f;
endpackage : dpt_pkg

// ===== core/dpt_timer.sv
// Purpose: two 8-bit down timers, chainable to 16 bits, with flags, clock output and serial clock
// Assumes: oscillator inputs are one-cycle tick strobes synchronous to i_ref_clk
// Notes: avalon-mm slave, one wait cycle per access, data in the low byte
`timescale 1ns/100ps
module dpt_timer
    import dpt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [DPT_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_slow_oscillator,
    input wire logic i_fast_oscillator,
    output logic o_t0_irq,
    output logic o_t1_irq,
    output logic [1:0] o_irq_prio,
    output logic [23:0] o_irq_vector,
    output logic o_divided_clock_out,
    output logic o_shared_output_pin,
    output logic o_serial_clk
);

    // prescaler hit: counter has reached the terminal value for the code
    function automatic logic psc_hit(input logic [5:0] cnt, input logic [1:0] code);
        logic [5:0] m;
        case (code)
            2'h0: m = DPT_MASK_D1;
            2'h1: m = DPT_MASK_D4;
            2'h2: m = DPT_MASK_D16;
            default: m = DPT_MASK_D64;
        endcase
        return (cnt & m) == m;
    endfunction

    logic wait_q;
    logic [31:0] rdata_q;
    logic [4:0] mode_q;
    logic [1:0] prio_q;
    logic [1:0] ien_q;
    logic [1:0] flag_q;
    logic [1:0] div0_q, div1_q;
    logic t0_repeat_select_q, t1_repeat_select_q, run0_q, run1_q;
    logic [7:0] rld0_q, rld1_q, cnt0_q, cnt1_q;
    logic [5:0] psc0_q, psc1_q;
    logic hold_q;
    logic [7:0] hold_val_q;
    logic divided_clock_out_q, pin_q, ser_q, t0_irq_q, t1_irq_q;
    logic [1:0] prio_out_q;
    logic [23:0] vec_q;
    logic chain, req, wr_en, rd_ack, wr_lo;
    logic [15:0] idx;
    logic src0, src1, tick0, tick1, uf0, uf1, uf16, t1_ev, t0_ev, ck_ev;
    logic t0_load_strobe, t1_load_strobe;
    logic [7:0] wdat;
    logic [31:0] rdata_d;

    // bus decode: one wait cycle, access completes when waitrequest is low
    assign req = i_avs_read | i_avs_write;
    assign idx = i_avs_address[DPT_ADDR_W-1:2];
    assign wr_en = i_avs_write & ~wait_q;
    assign wr_lo = wr_en & i_avs_byteenable[0];
    assign rd_ack = i_avs_read & ~wait_q;
    assign wdat = i_avs_writedata[7:0];
    assign chain = mode_q[DPT_B_CHAIN];

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // read data mux, unmapped indices read zero
    always_comb begin
        rdata_d = 32'h0;
        case (idx)
            DPT_IDX_PRIO: rdata_d[DPT_B_PRIOHI:DPT_B_PRIOLO] = prio_q;
            DPT_IDX_IEN: rdata_d[DPT_B_T1:DPT_B_T0] = ien_q;
            DPT_IDX_FLAG: rdata_d[DPT_B_T1:DPT_B_T0] = flag_q;
            DPT_IDX_MODE: rdata_d[4:0] = mode_q;
            DPT_IDX_CTRL0: rdata_d[4:0] = {div0_q, t0_repeat_select_q, 1'b0, run0_q};
            DPT_IDX_CTRL1: rdata_d[4:0] = {div1_q, t1_repeat_select_q, 1'b0, run1_q};
            DPT_IDX_RLD0: rdata_d[7:0] = rld0_q;
            DPT_IDX_RLD1: rdata_d[7:0] = rld1_q;
            DPT_IDX_CNT0: rdata_d[7:0] = cnt0_q;
            DPT_IDX_CNT1: rdata_d[7:0] = hold_q ? hold_val_q : cnt1_q;
            default: rdata_d = 32'h0;
        endcase
    end

    // read data captured while waiting, stands during the acknowledge cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_q <= 32'h0;
        end else if (i_avs_read & wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    // chained readout: reading the low byte freezes the high byte until it is read
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            hold_q <= 1'b0;
            hold_val_q <= DPT_CNT_RST;
        end else if (rd_ack && idx == DPT_IDX_CNT0 && chain) begin
            hold_q <= 1'b1;
            hold_val_q <= cnt1_q;
        end else if ((rd_ack && idx == DPT_IDX_CNT1) || !chain) begin
            hold_q <= 1'b0;
        end
    end

    // configuration registers written by software
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            mode_q <= 5'h0;
            prio_q <= 2'h0;
            ien_q <= 2'h0;
            div0_q <= DPT_DIV_RST;
            div1_q <= DPT_DIV_RST;
            t0_repeat_select_q <= 1'b0;
            t1_repeat_select_q <= 1'b0;
            rld0_q <= DPT_RLD_RST;
            rld1_q <= DPT_RLD_RST;
        end else if (wr_lo) begin
            case (idx)
                DPT_IDX_PRIO: prio_q <= wdat[DPT_B_PRIOHI:DPT_B_PRIOLO];
                DPT_IDX_IEN: ien_q <= wdat[DPT_B_T1:DPT_B_T0];
                DPT_IDX_MODE: mode_q <= wdat[4:0];
                DPT_IDX_CTRL0: begin
                    div0_q <= wdat[DPT_B_DIVHI:DPT_B_DIVLO];
                    t0_repeat_select_q <= wdat[DPT_B_CONT];
                end
                DPT_IDX_CTRL1: begin
                    div1_q <= wdat[DPT_B_DIVHI:DPT_B_DIVLO];
                    t1_repeat_select_q <= wdat[DPT_B_CONT];
                end
                DPT_IDX_RLD0: rld0_q <= wdat;
                DPT_IDX_RLD1: rld1_q <= wdat;
                default: ;
            endcase
        end
    end

    // preset strobes, never stored
    assign t0_load_strobe = wr_lo && idx == DPT_IDX_CTRL0 && wdat[DPT_B_PSET];
    assign t1_load_strobe = wr_lo && idx == DPT_IDX_CTRL1 && wdat[DPT_B_PSET] && !chain;

    // source and prescaler: chained mode runs everything from timer 0 settings
    assign src0 = mode_q[DPT_B_SRC0] ? i_fast_oscillator : i_slow_oscillator;
    assign src1 = mode_q[DPT_B_SRC1] ? i_fast_oscillator : i_slow_oscillator;
    assign tick0 = run0_q & src0 & psc_hit(psc0_q, div0_q);
    assign tick1 = run1_q & ~chain & src1 & psc_hit(psc1_q, div1_q);

    // prescalers only advance while their timer runs
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            psc0_q <= 6'h0;
            psc1_q <= 6'h0;
        end else begin
            if (!run0_q) begin
                psc0_q <= 6'h0;
            end else if (src0) begin
                psc0_q <= tick0 ? 6'h0 : psc0_q + 6'h1;
            end
            if (!run1_q || chain) begin
                psc1_q <= 6'h0;
            end else if (src1) begin
                psc1_q <= tick1 ? 6'h0 : psc1_q + 6'h1;
            end
        end
    end

    // underflow events
    assign uf0 = tick0 && cnt0_q == 8'h0;
    assign uf16 = chain && uf0 && cnt1_q == 8'h0;
    assign uf1 = tick1 && cnt1_q == 8'h0;
    assign t1_ev = chain ? uf16 : uf1;
    assign t0_ev = ~chain & uf0;
    assign ck_ev = chain ? uf16 : (mode_q[DPT_B_CLKOUT_SOURCE_SELECT] ? uf1 : uf0);

    // counters: preset beats counting, underflow reloads
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt0_q <= DPT_CNT_RST;
            cnt1_q <= DPT_CNT_RST;
        end else begin
            if (t0_load_strobe) begin
                cnt0_q <= rld0_q;
            end else if (tick0) begin
                if (cnt0_q != 8'h0) begin
                    cnt0_q <= cnt0_q - 8'h1;
                end else if (chain && !uf16) begin
                    cnt0_q <= 8'hff; // low byte borrows into the high byte
                end else begin
                    cnt0_q <= rld0_q;
                end
            end
            if (chain) begin
                if (t0_load_strobe || uf16) begin
                    cnt1_q <= rld1_q;
                end else if (uf0) begin
                    cnt1_q <= cnt1_q - 8'h1;
                end
            end else if (t1_load_strobe) begin
                cnt1_q <= rld1_q;
            end else if (tick1) begin
                cnt1_q <= (cnt1_q == 8'h0) ? rld1_q : cnt1_q - 8'h1;
            end
        end
    end

    // run bits: software write wins, one-shot underflow stops the timer
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            run0_q <= 1'b0;
            run1_q <= 1'b0;
        end else begin
            if (wr_lo && idx == DPT_IDX_CTRL0) begin
                run0_q <= wdat[DPT_B_RUN];
            end else if (!t0_repeat_select_q && (chain ? uf16 : uf0)) begin
                run0_q <= 1'b0;
            end
            if (chain) begin
                run1_q <= 1'b0;
            end else if (wr_lo && idx == DPT_IDX_CTRL1) begin
                run1_q <= wdat[DPT_B_RUN];
            end else if (!t1_repeat_select_q && uf1) begin
                run1_q <= 1'b0;
            end
        end
    end

    // sticky flags: hardware set wins over a same-cycle write-one clear
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            flag_q <= 2'h0;
        end else begin
            if (t1_ev) begin
                flag_q[1] <= 1'b1;
            end else if (wr_lo && idx == DPT_IDX_FLAG && wdat[DPT_B_T1]) begin
                flag_q[1] <= 1'b0;
            end
            if (t0_ev) begin
                flag_q[0] <= 1'b1;
            end else if (wr_lo && idx == DPT_IDX_FLAG && wdat[DPT_B_T0]) begin
                flag_q[0] <= 1'b0;
            end
        end
    end

    // interrupt requests, priority and vector toward the cpu
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            t0_irq_q <= 1'b0;
            t1_irq_q <= 1'b0;
            prio_out_q <= 2'h0;
            vec_q <= DPT_VEC_T1;
        end else begin
            t0_irq_q <= flag_q[0] & ien_q[0];
            t1_irq_q <= flag_q[1] & ien_q[1];
            prio_out_q <= prio_q;
            vec_q <= (flag_q[1] & ien_q[1]) ? DPT_VEC_T1 : DPT_VEC_T0;
        end
    end

    // divided clock, pin gating and serial clock strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            divided_clock_out_q <= 1'b0;
            pin_q <= 1'b1;
            ser_q <= 1'b0;
        end else begin
            divided_clock_out_q <= ck_ev ? ~divided_clock_out_q : divided_clock_out_q;
            // gating is registered here, so switching cannot glitch shorter than a clock
            pin_q <= mode_q[DPT_B_CKEN] ? divided_clock_out_q : 1'b1;
            ser_q <= t1_ev;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_t0_irq = t0_irq_q;
    assign o_t1_irq = t1_irq_q;
    assign o_irq_prio = prio_out_q;
    assign o_irq_vector = vec_q;
    assign o_divided_clock_out = divided_clock_out_q;
    assign o_shared_output_pin = pin_q;
    assign o_serial_clk = ser_q;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    flag_set_a: assert property (t1_ev |=> flag_q[1])
        else $error("timer 1 flag not set after underflow");
    irq_mask_a: assert property (t0_irq_q |-> $past(ien_q[0] && flag_q[0]))
        else $error("timer 0 request without enable and flag");
    prio_out_a: assert property (##1 o_irq_prio == $past(prio_q))
        else $error("priority output does not follow register");
    vector_a: assert property (t1_irq_q |-> vec_q == DPT_VEC_T1)
        else $error("wrong vector for timer 1 request");
    chain_noflag_a: assert property ($past(chain) && !$past(wr_lo) |-> !$rose(flag_q[0]))
        else $error("timer 0 flag set in chained mode");
    divided_clock_out_toggle_a: assert property (ck_ev |=> divided_clock_out_q != $past(divided_clock_out_q))
        else $error("clock output did not toggle");
    pin_high_a: assert property (!mode_q[DPT_B_CKEN] |=> pin_q)
        else $error("shared pin not high while disabled");
    oneshot_stop_a: assert property (uf0 && !chain && !t0_repeat_select_q && !wr_lo |=> !run0_q ##1 (!run0_q || $past(wr_lo)))
        else $error("one-shot timer 0 kept running");
    preset_load_a: assert property (t0_load_strobe |=> cnt0_q == $past(rld0_q))
        else $error("preset did not load counter");
    reload_t1_a: assert property (uf1 && !t1_load_strobe |=> cnt1_q == $past(rld1_q))
        else $error("timer 1 not reloaded on underflow");
    serial_clk_a: assert property (t1_ev |=> o_serial_clk)
        else $error("serial clock strobe missing");

    // flags stick until cleared, requests follow the enables
    flag_clr_a: assert property (wr_lo && idx == DPT_IDX_FLAG && wdat[DPT_B_T0] && !t0_ev |=> !flag_q[0])
        else $error("timer 0 flag not cleared by write");
    flag_keep_a: assert property (flag_q[1] && !(wr_lo && wdat[DPT_B_T1]) |=> flag_q[1])
        else $error("timer 1 flag dropped without clear");
    irq_enable_a: assert property (o_t1_irq |-> $past(ien_q[1]))
        else $error("timer 1 request while disabled");
    vector_t0_a: assert property (o_t0_irq && !o_t1_irq |-> o_irq_vector == DPT_VEC_T0)
        else $error("wrong vector for timer 0 request");
    chain_flag0_a: assert property (chain && !(wr_lo && idx == DPT_IDX_FLAG) |=> $stable(flag_q[0]))
        else $error("timer 0 flag moved in chained mode");

    // clock output source selection and pin
    divided_clock_out_hold_a: assert property (!ck_ev |=> $stable(divided_clock_out_q))
        else $error("clock output toggled without underflow");
    clkout_source_select_src_a: assert property (!chain && (mode_q[DPT_B_CLKOUT_SOURCE_SELECT] ? !uf1 : !uf0) |=> $stable(divided_clock_out_q))
        else $error("clock output followed unselected timer");
    chain_clk_a: assert property (chain && !uf16 |=> $stable(divided_clock_out_q))
        else $error("chained clock output moved without 16-bit underflow");
    pin_follow_a: assert property (mode_q[DPT_B_CKEN] |=> pin_q == $past(divided_clock_out_q))
        else $error("shared pin does not follow clock output");
    serial_only_a: assert property (!t1_ev |=> !o_serial_clk)
        else $error("serial clock strobe without underflow");

    // counters, reloads and run bits
    src_sel_a: assert property (run0_q && !mode_q[DPT_B_SRC0] && !i_slow_oscillator
        && !t0_load_strobe |=> $stable(cnt0_q)) else $error("fast tick counted on slow source");
    cnt0_hold_a: assert property (!run0_q && !t0_load_strobe |=> $stable(cnt0_q))
        else $error("stopped timer 0 counted");
    cnt1_hold_a: assert property (!run1_q && !chain && !t1_load_strobe |=> $stable(cnt1_q))
        else $error("stopped timer 1 counted");
    ro_count_a: assert property (wr_lo && idx == DPT_IDX_CNT0 && !tick0 |=> $stable(cnt0_q))
        else $error("count readout took a write");
    reload_keep_a: assert property (!(wr_lo && idx == DPT_IDX_RLD0) |=> $stable(rld0_q))
        else $error("reload value changed without write");
    reload_t0_a: assert property (uf0 && !chain && !t0_load_strobe |=> cnt0_q == $past(rld0_q))
        else $error("timer 0 not reloaded on underflow");
    chain_run1_a: assert property (chain |=> !run1_q)
        else $error("timer 1 runs in chained mode");

    // main scenarios reached
    chain_uf_c: cover property (uf16 ##1 flag_q[1]);
    oneshot_c: cover property (uf0 && !t0_repeat_select_q ##1 !run0_q);
    divided_clock_out_pin_c: cover property (mode_q[DPT_B_CKEN] && ck_ev ##2 $changed(pin_q));
    chain_rd_c: cover property (hold_q ##1 !hold_q);
    flag_clr_c: cover property (flag_q[0] ##1 !flag_q[0]);

endmodule // dpt_timer

// ===== testbench/dpt_osc_model.sv
// Purpose: oscillator tick source standing in for the slow and fast clock circuits
// Assumes: ticks are one-cycle strobes synchronous to the reference clock
// Notes: the bench calls burst to emit an exact number of ticks on one source
`timescale 1ns/100ps
module dpt_osc_model (
    input wire logic i_ref_clk,
    output logic o_slow_oscillator,
    output logic o_fast_oscillator
);
    // idle until asked
    initial begin
        o_slow_oscillator = 1'b0;
        o_fast_oscillator = 1'b0;
    end
    // n ticks with one idle cycle between them, changed just after an edge
    task automatic burst(input logic fast, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_ref_clk);
            o_fast_oscillator <= fast;
            o_slow_oscillator <= ~fast;
            @(posedge i_ref_clk);
            o_fast_oscillator <= 1'b0;
            o_slow_oscillator <= 1'b0;
        end
    endtask
endmodule // dpt_osc_model

// ===== testbench/tb_dual_programmable_timer.sv
// Purpose: self-checking bench for the dual programmable timer
// Assumes: avalon-mm master with one request in flight; ticks from the oscillator model
// Notes: each scenario is a task that drives the block and judges what comes back
`timescale 1ns/100ps
module tb_dual_programmable_timer;
    import dpt_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [DPT_ADDR_W-1:0] avs_addr = '0;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wdata = '0;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic slow_tick, fast_tick, t0_irq, t1_irq, div_clk, pin, ser_clk;
    logic [1:0] prio;
    logic [23:0] vec;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int ser_cnt = 0;
    // reference clock, 40 ns period
    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    dpt_timer dut_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_avs_address(avs_addr), .i_avs_read(avs_rd),
        .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(avs_wait), .i_slow_oscillator(slow_tick), .i_fast_oscillator(fast_tick),
        .o_t0_irq(t0_irq), .o_t1_irq(t1_irq), .o_irq_prio(prio), .o_irq_vector(vec),
        .o_divided_clock_out(div_clk), .o_shared_output_pin(pin), .o_serial_clk(ser_clk));
    dpt_osc_model osc_u (.i_ref_clk(i_ref_clk), .o_slow_oscillator(slow_tick), .o_fast_oscillator(fast_tick));
    // hang guard and serial clock pulse counter
    always @(posedge i_ref_clk) begin
        cyc++;
        if (ser_clk === 1'b1) ser_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus cycle: hold until waitrequest is sampled low, take data at that edge
    task automatic bus_xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge i_ref_clk);
        avs_addr <= {idx, 2'b00};
        avs_wdata <= {24'h000000, wd};
        avs_wr <= wr;
        avs_rd <= ~wr;
        do @(posedge i_ref_clk); while (avs_wait !== 1'b0);
        rd = avs_rdata[7:0];
        avs_wr <= 1'b0;
        avs_rd <= 1'b0;
    endtask
    task automatic wr_reg(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        bus_xfer(idx, 1'b1, d, unused);
    endtask
    task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [7:0] e);
        logic [7:0] g;
        bus_xfer(idx, 1'b0, 8'h00, g);
        chk_reg(nm, e, g);
    endtask
    // ticks, then enough cycles for flag, request and output registers to settle
    task automatic tick(input logic fast, input int n);
        osc_u.burst(fast, n);
        repeat (4) @(posedge i_ref_clk);
    endtask
    // reset values, unmapped place, read-only readout
    task automatic t_reset();
        logic [15:0] idx [11] = '{DPT_IDX_PRIO, DPT_IDX_IEN, DPT_IDX_FLAG, DPT_IDX_MODE, DPT_IDX_CTRL0,
            DPT_IDX_CTRL1, DPT_IDX_RLD0, DPT_IDX_RLD1, DPT_IDX_CNT0, DPT_IDX_CNT1, 16'hff40};
        logic [7:0] exp [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
        chk_pin("pin at reset", 24'h000001, {23'h0, pin});
        for (int k = 0; k < 11; k++) begin
            rd_chk("reset value", idx[k], exp[k]);
        end
        wr_reg(DPT_IDX_CNT0, 8'h12);
        rd_chk("readout write", DPT_IDX_CNT0, 8'hff);
        wr_reg(DPT_IDX_RLD0, 8'h5a);
        rd_chk("reload rw", DPT_IDX_RLD0, 8'h5a);
    endtask
    // timer 0 underflow, flag clearing, masking, stop, one-shot
    task automatic t_timer0();
        wr_reg(DPT_IDX_IEN, 8'h40);
        rd_chk("ien t0", DPT_IDX_IEN, 8'h40);
        wr_reg(DPT_IDX_RLD0, 8'h02);
        wr_reg(DPT_IDX_CTRL0, 8'h07);
        rd_chk("ctrl0", DPT_IDX_CTRL0, 8'h05);
        rd_chk("preset count", DPT_IDX_CNT0, 8'h02);
        tick(1'b0, 3);
        rd_chk("flag t0", DPT_IDX_FLAG, 8'h40);
        chk_pin("t0 irq", 24'h000001, {23'h0, t0_irq});
        chk_pin("vector t0", DPT_VEC_T0, vec);
        rd_chk("reloaded", DPT_IDX_CNT0, 8'h02);
        wr_reg(DPT_IDX_FLAG, 8'h00);
        rd_chk("flag kept", DPT_IDX_FLAG, 8'h40);
        wr_reg(DPT_IDX_FLAG, 8'h40);
        rd_chk("flag cleared", DPT_IDX_FLAG, 8'h00);
        chk_pin("t0 irq off", 24'h000000, {23'h0, t0_irq});
        wr_reg(DPT_IDX_IEN, 8'h00);
        tick(1'b0, 3);
        rd_chk("masked flag", DPT_IDX_FLAG, 8'h40);
        chk_pin("masked irq", 24'h000000, {23'h0, t0_irq});
        wr_reg(DPT_IDX_FLAG, 8'h40);
        wr_reg(DPT_IDX_CTRL0, 8'h04);
        tick(1'b0, 5);
        rd_chk("stopped", DPT_IDX_CNT0, 8'h02);
        wr_reg(DPT_IDX_RLD0, 8'h01);
        wr_reg(DPT_IDX_CTRL0, 8'h03);
        tick(1'b0, 2);
        rd_chk("one-shot run", DPT_IDX_CTRL0, 8'h00);
        rd_chk("one-shot count", DPT_IDX_CNT0, 8'h01);
        wr_reg(DPT_IDX_FLAG, 8'h40);
    endtask
    // every divider code on the fast source; slow ticks then ignored
    task automatic t_prescale();
        wr_reg(DPT_IDX_MODE, 8'h01);
        wr_reg(DPT_IDX_RLD0, 8'h10);
        for (int c = 0; c < 4; c++) begin
            wr_reg(DPT_IDX_CTRL0, {3'h0, 2'(c), 3'h0});
            wr_reg(DPT_IDX_CTRL0, {3'h0, 2'(c), 3'h7});
            tick(1'b1, (1 << (2 * c)) - 1);
            rd_chk("div hold", DPT_IDX_CNT0, 8'h10);
            tick(1'b1, 1);
            rd_chk("div step", DPT_IDX_CNT0, 8'h0f);
        end
        tick(1'b0, 8);
        rd_chk("slow ignored", DPT_IDX_CNT0, 8'h0f);
        wr_reg(DPT_IDX_CTRL0, 8'h00);
    endtask
    // clock output source, pin gating and serial clock, underflow every tick
    task automatic t_clkout();
        logic e;
        int n;
        wr_reg(DPT_IDX_RLD1, 8'h00); // reload 00 is a permitted serial rate setting
        wr_reg(DPT_IDX_RLD0, 8'h00);
        wr_reg(DPT_IDX_CTRL1, 8'h07);
        wr_reg(DPT_IDX_CTRL0, 8'h07);
        for (int s = 0; s < 2; s++) begin
            wr_reg(DPT_IDX_MODE, {4'h0, 1'(s), 3'h5}); // pin gets the clock output, timer 0 on fast, timer 1 on slow source
            for (int f = 0; f < 2; f++) begin
                e = div_clk ^ 1'(f ^ s);
                n = ser_cnt + (f == 0);
                tick(1'(f), 1);
                chk_pin("clock out", {23'h0, e}, {23'h0, div_clk});
                chk_pin("pin drives", {23'h0, e}, {23'h0, pin});
                chk_pin("serial pulses", 24'(n), 24'(ser_cnt));
            end
        end
        wr_reg(DPT_IDX_MODE, 8'h09);
        e = ~div_clk;
        tick(1'b0, 1);
        chk_pin("gated toggle", {23'h0, e}, {23'h0, div_clk});
        chk_pin("pin high", 24'h000001, {23'h0, pin});
        wr_reg(DPT_IDX_CTRL0, 8'h00);
        wr_reg(DPT_IDX_CTRL1, 8'h00);
        wr_reg(DPT_IDX_FLAG, 8'hc0);
    endtask
    // chained 16-bit count, flags, vector, clock output, priority
    task automatic t_chain();
        logic e;
        wr_reg(DPT_IDX_MODE, 8'h1c); // source select set, chained mode must ignore it
        wr_reg(DPT_IDX_RLD0, 8'h01);
        wr_reg(DPT_IDX_RLD1, 8'h01);
        wr_reg(DPT_IDX_IEN, 8'hc0);
        wr_reg(DPT_IDX_CTRL0, 8'h07);
        tick(1'b0, 257);
        rd_chk("low byte", DPT_IDX_CNT0, 8'h00);
        rd_chk("high byte", DPT_IDX_CNT1, 8'h00);
        rd_chk("no flag yet", DPT_IDX_FLAG, 8'h00);
        e = ~div_clk;
        tick(1'b0, 1);
        rd_chk("chain flag", DPT_IDX_FLAG, 8'h80);
        chk_pin("t1 irq", 24'h000001, {23'h0, t1_irq});
        chk_pin("no t0 irq", 24'h000000, {23'h0, t0_irq});
        chk_pin("vector t1", DPT_VEC_T1, vec);
        chk_pin("chain clock", {23'h0, e}, {23'h0, div_clk});
        rd_chk("low reload", DPT_IDX_CNT0, 8'h01);
        rd_chk("high reload", DPT_IDX_CNT1, 8'h01);
        for (int p = 0; p < 4; p++) begin
            wr_reg(DPT_IDX_PRIO, {4'h0, 2'(p), 2'h0});
            repeat (3) @(posedge i_ref_clk);
            chk_pin("priority", 24'(p), {22'h0, prio});
        end
        wr_reg(DPT_IDX_CTRL0, 8'h00);
        wr_reg(DPT_IDX_FLAG, 8'hc0);
    endtask
    // reset for 12 cycles, then the scenarios
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        t_reset();
        t_timer0();
        t_prescale();
        t_clkout();
        t_chain();
        close_out();
    end
endmodule // tb_dual_programmable_timer
